// file: include/hppc_map.svh
// register offsets, field positions, reset values and widths for the port power config bank
`ifndef HPPC_MAP_SVH
`define HPPC_MAP_SVH
`define HPPC_ADDR_W 8
`define HPPC_DATA_W 8
`define HPPC_NPORT 8
`define HPPC_OFS_BP_MASK 8'h0B
`define HPPC_OFS_SP_BUDGET 8'h0C
`define HPPC_OFS_BP_BUDGET 8'h0D
`define HPPC_OFS_SP_DRAW 8'h0E
`define HPPC_RST_BP_MASK 8'h00
`define HPPC_RST_SP_BUDGET 8'h00
`define HPPC_RST_BP_BUDGET 8'h00
`define HPPC_RST_SP_DRAW 8'h32
`define HPPC_RSVD_BIT 0
`define HPPC_RSVD_CLR 8'hFE
`define HPPC_PORT_ONE 3'h1
`define HPPC_CNT_ZERO 3'h0
`define HPPC_CNT_ONE 3'h1
`define HPPC_ZERO8 8'h00
`define HPPC_SP_LIMIT 8'h32
`endif

// file: include/hppc_pkg.sv
// types for the port power config bank
package hppc_pkg;
  typedef logic [7:0] hppc_byte_t;
  typedef logic [2:0] hppc_port_t;
  typedef enum logic [1:0] {
    HPPC_SRC_IDLE = 2'b00,
    HPPC_SRC_LOAD = 2'b01,
    HPPC_SRC_STRAP = 2'b10
  } hppc_src_t;
endpackage : hppc_pkg

// file: include/hppc_cfg_if.sv
// mask and remap results passed between the bank and the port mapper
interface hppc_cfg_if;
  logic [7:0] off_mask;
  logic remap_en;
  logic [7:0] port_active;
  logic [2:0] active_count;
  logic [23:0] logical_num;
  modport bank (output off_mask, output remap_en,
    input port_active, input active_count, input logical_num);
  modport mapper (input off_mask, input remap_en,
    output port_active, output active_count, output logical_num);
endinterface : hppc_cfg_if

// file: rtl/hppc_port_mapper.sv
// renumbers enabled ports and counts them
`include "hppc_map.svh"
module hppc_port_mapper
  import hppc_pkg::*;
(
  hppc_cfg_if.mapper cfg
);
  logic [7:0] active;
  logic [2:0] cnt [8];
  // port usable in mapping mode, or when standard mode leaves it unmasked
  genvar g;
  generate
    for (g = 1; g < `HPPC_NPORT; g++) begin : g_port
      assign active[g] = cfg.remap_en | ~cfg.off_mask[g]; // RULE3 RULE11
      assign cnt[g] = cnt[g-1] + (active[g] ? `HPPC_CNT_ONE : `HPPC_CNT_ZERO); // RULE4
      assign cfg.logical_num[g*3 +: 3] = active[g] ? cnt[g] : `HPPC_CNT_ZERO; // RULE4
    end
  endgenerate
  assign active[`HPPC_RSVD_BIT] = 1'b0;
  assign cnt[0] = `HPPC_CNT_ZERO;
  assign cfg.logical_num[2:0] = `HPPC_CNT_ZERO;
  assign cfg.port_active = active;
  assign cfg.active_count = cnt[7]; // RULE4
endmodule : hppc_port_mapper

// file: rtl/hppc_power_sel.sv
// picks power figures for the present power mode
`include "hppc_map.svh"
module hppc_power_sel
  import hppc_pkg::*;
(
  input wire logic self_powered,
  input wire hppc_byte_t sp_budget,
  input wire hppc_byte_t bp_budget,
  input wire hppc_byte_t sp_draw,
  output hppc_byte_t budget_sel,
  output hppc_byte_t draw_sel
);
  assign budget_sel = self_powered ? sp_budget : bp_budget; // RULE12 RULE6 RULE7
  assign draw_sel = self_powered ? sp_draw : `HPPC_ZERO8; // RULE8
endmodule : hppc_power_sel

// file: rtl/hppc_bank.sv
// port power configuration register bank
`include "hppc_map.svh"
// Operation
// RULE1: mask bit n high disables downstream port n, low leaves it available.
// RULE2: mask bit 0 is reserved and always reads zero.
// RULE3: in standard mode masked ports stay disabled and never enumerate.
// RULE4: any mask accepted; report enabled count and renumber active ports.
// RULE5: internal default derives disabled ports from the per-port straps.
// RULE6: self-powered budget is upstream current in 2 mA steps.
// RULE7: bus-powered budget is upstream current in 2 mA steps.
// RULE8: self-powered controller draw in 2 mA steps, excludes attached peripheral.
// RULE9: controller draw resets to 50, meaning 100 mA.
// RULE10: source must not load self-powered figures above 100 mA.
// RULE11: remap enable low means standard mode; high means port mapping mode.
// RULE12: power figures follow present power mode into reported descriptors.
module hppc_bank
  import hppc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic use_defaults,
  input wire logic [7:0] port_off_strap_plus,
  input wire logic [7:0] port_off_strap_minus,
  input wire logic port_remap_enable,
  input wire logic self_powered,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic [7:0] port_enabled,
  output logic [2:0] enabled_count,
  output logic [23:0] port_number_map,
  output logic [7:0] reported_budget,
  output logic [7:0] reported_draw,
  output logic sp_limit_over
);
  hppc_byte_t bus_power_port_off_mask_q;
  hppc_byte_t self_power_budget_q;
  hppc_byte_t bus_power_budget_q;
  hppc_byte_t self_power_controller_draw_q;
  hppc_byte_t strap_mask;
  hppc_byte_t eff_mask;
  hppc_byte_t budget_sel;
  hppc_byte_t draw_sel;
  hppc_byte_t rd_d;

  hppc_cfg_if cfg ();

  function automatic hppc_byte_t rd_mux(input logic [7:0] a, input hppc_byte_t m,
      input hppc_byte_t sb, input hppc_byte_t bb, input hppc_byte_t sd);
    unique case (a)
      `HPPC_OFS_BP_MASK: rd_mux = m & `HPPC_RSVD_CLR; // RULE2
      `HPPC_OFS_SP_BUDGET: rd_mux = sb;
      `HPPC_OFS_BP_BUDGET: rd_mux = bb;
      `HPPC_OFS_SP_DRAW: rd_mux = sd;
      default: rd_mux = `HPPC_ZERO8;
    endcase
  endfunction : rd_mux

  // register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_power_port_off_mask_q <= `HPPC_RST_BP_MASK;
      self_power_budget_q <= `HPPC_RST_SP_BUDGET;
      bus_power_budget_q <= `HPPC_RST_BP_BUDGET;
      self_power_controller_draw_q <= `HPPC_RST_SP_DRAW; // RULE9
    end else if (cfg_wr) begin
      unique case (cfg_addr)
        `HPPC_OFS_BP_MASK: bus_power_port_off_mask_q <= cfg_wdata & `HPPC_RSVD_CLR; // RULE1 RULE2
        `HPPC_OFS_SP_BUDGET: self_power_budget_q <= cfg_wdata; // RULE6
        `HPPC_OFS_BP_BUDGET: bus_power_budget_q <= cfg_wdata; // RULE7
        `HPPC_OFS_SP_DRAW: self_power_controller_draw_q <= cfg_wdata; // RULE8
        default: ;
      endcase
    end
  end

  // strap or loaded mask
  assign strap_mask = (port_off_strap_plus | port_off_strap_minus) & `HPPC_RSVD_CLR; // RULE5
  assign eff_mask = use_defaults ? strap_mask : bus_power_port_off_mask_q; // RULE5 RULE1
  assign cfg.off_mask = eff_mask;
  assign cfg.remap_en = port_remap_enable; // RULE11

  hppc_port_mapper u_map (
    .cfg(cfg.mapper)
  );

  hppc_power_sel u_pwr (
    .self_powered(self_powered),
    .sp_budget(self_power_budget_q),
    .bp_budget(bus_power_budget_q),
    .sp_draw(self_power_controller_draw_q),
    .budget_sel(budget_sel),
    .draw_sel(draw_sel)
  );

  assign rd_d = rd_mux(cfg_addr, bus_power_port_off_mask_q, self_power_budget_q,
    bus_power_budget_q, self_power_controller_draw_q);

  // read data, one cycle after the read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata <= `HPPC_ZERO8;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      cfg_rdata <= cfg_rd ? rd_d : `HPPC_ZERO8;
    end
  end

  // registered port status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_enabled <= `HPPC_ZERO8;
      enabled_count <= `HPPC_CNT_ZERO;
      port_number_map <= '0;
    end else begin
      port_enabled <= cfg.port_active; // RULE3
      enabled_count <= cfg.active_count; // RULE4
      port_number_map <= cfg.logical_num; // RULE4
    end
  end

  // registered power figures
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reported_budget <= `HPPC_ZERO8;
      reported_draw <= `HPPC_ZERO8;
      sp_limit_over <= 1'b0;
    end else begin
      reported_budget <= budget_sel; // RULE12
      reported_draw <= draw_sel; // RULE12
      sp_limit_over <= (self_power_budget_q > `HPPC_SP_LIMIT) |
        (self_power_controller_draw_q > `HPPC_SP_LIMIT); // RULE10
    end
  end

  sequence s_wr_mask;
    cfg_wr && cfg_addr == `HPPC_OFS_BP_MASK;
  endsequence

  sequence s_wr_sp_budget;
    cfg_wr && cfg_addr == `HPPC_OFS_SP_BUDGET;
  endsequence

  sequence s_wr_bp_budget;
    cfg_wr && cfg_addr == `HPPC_OFS_BP_BUDGET;
  endsequence

  sequence s_wr_draw;
    cfg_wr && cfg_addr == `HPPC_OFS_SP_DRAW;
  endsequence

  sequence s_rd_mask;
    cfg_rd && !cfg_wr && cfg_addr == `HPPC_OFS_BP_MASK;
  endsequence

  sequence s_rd_sp_budget;
    cfg_rd && !cfg_wr && cfg_addr == `HPPC_OFS_SP_BUDGET;
  endsequence

  sequence s_rd_bp_budget;
    cfg_rd && !cfg_wr && cfg_addr == `HPPC_OFS_BP_BUDGET;
  endsequence

  sequence s_rd_draw;
    cfg_rd && !cfg_wr && cfg_addr == `HPPC_OFS_SP_DRAW;
  endsequence

  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (rst) cfg_rvalid |-> !cfg_rdata[`HPPC_RSVD_BIT];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one"); // RULE2

  property p_mask_disables;
    @(posedge ref_clk) disable iff (rst)
      (!port_remap_enable && eff_mask[3]) ##1 1'b1 |-> !port_enabled[3];
  endproperty
  a_mask_disables: assert property (p_mask_disables) else $error("masked port enabled"); // RULE3

  property p_port0_off;
    @(posedge ref_clk) disable iff (rst) !port_enabled[0];
  endproperty
  a_port0_off: assert property (p_port0_off) else $error("port zero enabled"); // RULE1

  property p_count;
    @(posedge ref_clk) disable iff (rst)
      !rst ##1 1'b1 |-> enabled_count == $past(cfg.active_count);
  endproperty
  a_count: assert property (p_count) else $error("count mismatch"); // RULE4

  property p_strap;
    @(posedge ref_clk) disable iff (rst) use_defaults && port_off_strap_plus[2]
      |-> eff_mask[2];
  endproperty
  a_strap: assert property (p_strap) else $error("strap not applied"); // RULE5

  property p_budget_sel;
    @(posedge ref_clk) disable iff (rst) self_powered ##1 1'b1
      |-> reported_budget == $past(self_power_budget_q);
  endproperty
  a_budget_sel: assert property (p_budget_sel) else $error("wrong budget"); // RULE12

  property p_bp_budget;
    @(posedge ref_clk) disable iff (rst) !self_powered ##1 1'b1
      |-> reported_budget == $past(bus_power_budget_q);
  endproperty
  a_bp_budget: assert property (p_bp_budget) else $error("wrong bus budget"); // RULE7

  property p_write;
    @(posedge ref_clk) disable iff (rst) s_wr_draw
      |=> self_power_controller_draw_q == $past(cfg_wdata);
  endproperty
  a_write: assert property (p_write) else $error("draw write lost"); // RULE8

  property p_reset_draw;
    @(posedge ref_clk) $fell(rst) |-> self_power_controller_draw_q == `HPPC_RST_SP_DRAW;
  endproperty
  a_reset_draw: assert property (p_reset_draw) else $error("draw reset wrong"); // RULE9

  property p_read_lat;
    @(posedge ref_clk) disable iff (rst) s_rd_sp_budget
      |=> cfg_rvalid && cfg_rdata == $past(self_power_budget_q);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data wrong"); // RULE6

  property p_wr_mask;
    @(posedge ref_clk) disable iff (rst)
      s_wr_mask |=> bus_power_port_off_mask_q == ($past(cfg_wdata) & `HPPC_RSVD_CLR);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("mask write lost"); // RULE1

  property p_wr_sp_budget;
    @(posedge ref_clk) disable iff (rst)
      s_wr_sp_budget |=> self_power_budget_q == $past(cfg_wdata);
  endproperty
  a_wr_sp_budget: assert property (p_wr_sp_budget) else $error("self budget lost"); // RULE6

  property p_wr_bp_budget;
    @(posedge ref_clk) disable iff (rst)
      s_wr_bp_budget |=> bus_power_budget_q == $past(cfg_wdata);
  endproperty
  a_wr_bp_budget: assert property (p_wr_bp_budget) else $error("bus budget lost"); // RULE7

  property p_rd_mask;
    @(posedge ref_clk) disable iff (rst)
      s_rd_mask |=> cfg_rvalid && cfg_rdata == ($past(bus_power_port_off_mask_q) & `HPPC_RSVD_CLR);
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong"); // RULE2

  property p_rd_bp_budget;
    @(posedge ref_clk) disable iff (rst)
      s_rd_bp_budget |=> cfg_rvalid && cfg_rdata == $past(bus_power_budget_q);
  endproperty
  a_rd_bp_budget: assert property (p_rd_bp_budget) else $error("bus budget read wrong"); // RULE7

  property p_rd_draw;
    @(posedge ref_clk) disable iff (rst)
      s_rd_draw |=> cfg_rvalid && cfg_rdata == $past(self_power_controller_draw_q);
  endproperty
  a_rd_draw: assert property (p_rd_draw) else $error("draw read wrong"); // RULE9

  property p_mask_bit0;
    @(posedge ref_clk) disable iff (rst) !bus_power_port_off_mask_q[`HPPC_RSVD_BIT];
  endproperty
  a_mask_bit0: assert property (p_mask_bit0) else $error("reserved mask bit set"); // RULE2

  property p_remap_all;
    @(posedge ref_clk) disable iff (rst)
      !rst && port_remap_enable |=> port_enabled == `HPPC_RSVD_CLR;
  endproperty
  a_remap_all: assert property (p_remap_all) else $error("mapping mode port off"); // RULE11

  property p_count_ones;
    @(posedge ref_clk) disable iff (rst) enabled_count == 3'($countones(port_enabled));
  endproperty
  a_count_ones: assert property (p_count_ones) else $error("count not enabled ports"); // RULE4

  property p_strap_mask;
    @(posedge ref_clk) disable iff (rst) !rst && use_defaults && !port_remap_enable
      |=> port_enabled == (~($past(port_off_strap_plus) | $past(port_off_strap_minus)) &
        `HPPC_RSVD_CLR);
  endproperty
  a_strap_mask: assert property (p_strap_mask) else $error("strap ports wrong"); // RULE5

  property p_draw_sel;
    @(posedge ref_clk) disable iff (rst)
      !rst && self_powered |=> reported_draw == $past(self_power_controller_draw_q);
  endproperty
  a_draw_sel: assert property (p_draw_sel) else $error("self draw wrong"); // RULE8

  property p_draw_bus;
    @(posedge ref_clk) disable iff (rst)
      !rst && !self_powered |=> reported_draw == `HPPC_ZERO8;
  endproperty
  a_draw_bus: assert property (p_draw_bus) else $error("bus draw not zero"); // RULE12

  genvar gp;
  generate
    for (gp = 1; gp < `HPPC_NPORT; gp++) begin : g_chk
      property p_port_num;
        @(posedge ref_clk) disable iff (rst) port_enabled[gp]
          |-> port_number_map[gp*3 +: 3] == 3'($countones(port_enabled[gp:1]));
      endproperty
      a_port_num: assert property (p_port_num) else $error("port number wrong"); // RULE4

      property p_port_gone;
        @(posedge ref_clk) disable iff (rst) !port_enabled[gp]
          |-> port_number_map[gp*3 +: 3] == `HPPC_CNT_ZERO;
      endproperty
      a_port_gone: assert property (p_port_gone) else $error("off port numbered"); // RULE4
    end
  endgenerate

endmodule : hppc_bank

// file: tb/hppc_cfg_src.sv
// configuration source model that loads and reads back the bank
`include "hppc_map.svh"
module hppc_cfg_src (
  input wire logic ref_clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic sp;
    sp = (a == `HPPC_OFS_SP_BUDGET) || (a == `HPPC_OFS_SP_DRAW);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= (sp && d > 8'h32) ? 8'h32 : d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    #1;
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask : rd
endmodule : hppc_cfg_src

// file: tb/tb_top.sv
// self-checking bench for the port power config bank
`include "hppc_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] m, sp, sm; logic ud, rm; logic [7:0] en;
    logic [2:0] cnt;} hppc_row_t;
  logic ref_clk;
  logic rst = 1'b1;
  logic cfg_wr, cfg_rd, cfg_rvalid, sp_limit_over;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, port_enabled, reported_budget, reported_draw;
  logic use_defaults = 1'b0;
  logic remap = 1'b0;
  logic self_powered = 1'b1;
  logic [7:0] strap_p = 8'h00;
  logic [7:0] strap_m = 8'h00;
  logic [2:0] enabled_count;
  logic [23:0] port_number_map;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  hppc_row_t rows [8] = '{
    '{8'h07, 8'h00, 8'h00, 1'b0, 1'b0, 8'hF8, 3'h5},
    '{8'h80, 8'h00, 8'h00, 1'b0, 1'b0, 8'h7E, 3'h6},
    '{8'hAA, 8'h00, 8'h00, 1'b0, 1'b0, 8'h54, 3'h3},
    '{8'hFC, 8'h00, 8'h00, 1'b0, 1'b0, 8'h02, 3'h1},
    '{8'hFE, 8'h00, 8'h00, 1'b0, 1'b1, 8'hFE, 3'h7},
    '{8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'hFE, 3'h7},
    '{8'h80, 8'h11, 8'h40, 1'b1, 1'b0, 8'hAE, 3'h5},
    '{8'h00, 8'h01, 8'h00, 1'b1, 1'b0, 8'hFE, 3'h7}};
  hppc_bank dut_u (.ref_clk(ref_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .use_defaults(use_defaults),
    .port_off_strap_plus(strap_p), .port_off_strap_minus(strap_m),
    .port_remap_enable(remap), .self_powered(self_powered), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .port_enabled(port_enabled), .enabled_count(enabled_count),
    .port_number_map(port_number_map), .reported_budget(reported_budget),
    .reported_draw(reported_draw), .sp_limit_over(sp_limit_over));
  hppc_cfg_src src_u (.ref_clk(ref_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [23:0] map_of(input logic [7:0] en);
    logic [2:0] n;
    map_of = '0;
    n = 3'h0;
    for (int p = 1; p < 8; p++) begin
      if (en[p]) begin
        n++;
        map_of[3*p +: 3] = n;
      end
    end
  endfunction : map_of
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    src_u.rd(a, d, v);
    chk("cfg_rvalid", 24'(1'b1), 24'(v));
    chk("cfg_rdata", 24'(e), 24'(d));
  endtask : rchk
  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      src_u.wr(`HPPC_OFS_BP_MASK, rows[i].m);
      use_defaults <= rows[i].ud;
      strap_p <= rows[i].sp;
      strap_m <= rows[i].sm;
      remap <= rows[i].rm;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("port_enabled", 24'(rows[i].en), 24'(port_enabled));
      chk("enabled_count", 24'(rows[i].cnt), 24'(enabled_count));
      chk("port_number_map", map_of(rows[i].en), port_number_map);
    end
    use_defaults <= 1'b0;
    src_u.wr(`HPPC_OFS_BP_MASK, 8'hFF);
    rchk(`HPPC_OFS_BP_MASK, 8'hFE);
    src_u.wr(`HPPC_OFS_SP_BUDGET, 8'h32);
    src_u.wr(`HPPC_OFS_BP_BUDGET, 8'h64);
    src_u.wr(`HPPC_OFS_SP_DRAW, 8'h28);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("reported_budget", 24'h32, 24'(reported_budget));
    chk("reported_draw", 24'h28, 24'(reported_draw));
    chk("sp_limit_over", 24'h0, 24'(sp_limit_over));
    @(posedge ref_clk);
    self_powered <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("reported_budget", 24'h64, 24'(reported_budget));
    chk("reported_draw", 24'h0, 24'(reported_draw));
    rchk(`HPPC_OFS_BP_BUDGET, 8'h64);
    rchk(8'h0F, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(`HPPC_OFS_SP_DRAW, 8'h32);
    rchk(`HPPC_OFS_SP_BUDGET, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
